// *** qdsl_pkg.sv ***
// Shared constants for the quad DAC serial load logic
package qdsl_pkg;
  localparam int unsigned  WORD_W        = 16;
  localparam int unsigned  CNT_W         = 5;
  localparam logic [4:0]   CNT_FULL      = 5'h10;
  localparam logic [4:0]   CNT_LAST      = 5'h0F;
  localparam int unsigned  NUM_CH        = 4;
  localparam int unsigned  CH_SEL_W      = 2;
  localparam int unsigned  CH_SELECT_HI  = 15;
  localparam int unsigned  CH_SELECT_LO  = 14;
  localparam int unsigned  PWR_CTL_POS   = 13;
  localparam int unsigned  UPD_ALL_POS   = 12;
  localparam int unsigned  CODE_MSB      = 11;
  localparam int unsigned  CODE_FIELD_W  = 12;
  localparam logic         PD_RST        = 1'h0;
  localparam logic         ACTIVE_RST    = 1'h1;
  localparam int unsigned  CORE_PERIOD_NS = 10;
  localparam int unsigned  PWRUP_TIME_NS = 2500;
  localparam int unsigned  PWRUP_CYC     = (PWRUP_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned  PWRUP_W       = $clog2(PWRUP_CYC + 1);
endpackage

// *** qdsl_link_rx.sv ***
// Serial-clock domain receiver: 16-bit shift register and frame completion toggle
`timescale 1ns/100ps
module qdsl_link_rx (
  input  wire logic                        i_sclk,
  input  wire logic                        i_arst_n,
  input  wire logic                        i_sync_n,
  input  wire logic                        i_din,
  output logic [qdsl_pkg::WORD_W-1:0]      o_word,
  output logic                             o_done_tgl
);
  logic [qdsl_pkg::CNT_W-1:0]  bit_cnt_ff;
  logic [qdsl_pkg::WORD_W-1:0] shift_ff;

  // Frame select high holds the counter at zero
  wire link_rst_n = i_arst_n & ~i_sync_n;
  wire rx_enable  = (bit_cnt_ff != qdsl_pkg::CNT_FULL);  // [R11]
  wire last_bit   = (bit_cnt_ff == qdsl_pkg::CNT_LAST);
  wire [qdsl_pkg::WORD_W-1:0] nxt_shift = {shift_ff[qdsl_pkg::WORD_W-2:0], i_din};
  wire [qdsl_pkg::CNT_W-1:0]  nxt_cnt   = bit_cnt_ff + 5'h01;

  always_ff @(negedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_ff <= 5'h00;
      shift_ff   <= 16'h0000;
    end else if (rx_enable) begin  // [R10] [R14] [R9]
      bit_cnt_ff <= nxt_cnt;
      shift_ff   <= nxt_shift;  // [R2] [R1]
    end
  end

  // Word and toggle survive frame select rising
  always_ff @(negedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_word     <= 16'h0000;
      o_done_tgl <= 1'h0;
    end else if (last_bit) begin  // [R12] [R13]
      o_word     <= nxt_shift;
      o_done_tgl <= ~o_done_tgl;
    end
  end

  a_cnt_saturate: assert property (  // [R11]
    @(negedge i_sclk) disable iff (!link_rst_n)
    bit_cnt_ff == qdsl_pkg::CNT_FULL |=> bit_cnt_ff == 5'h00
      || (bit_cnt_ff == qdsl_pkg::CNT_FULL && $stable(shift_ff)))
    else $error("Link kept shifting after sixteen bits");

  a_msb_first_shift: assert property (  // [R2]
    @(negedge i_sclk) disable iff (!link_rst_n)
    rx_enable |=> bit_cnt_ff == 5'h00
      || (shift_ff[0] == $past(i_din) && shift_ff[15:1] == $past(shift_ff[14:0])))
    else $error("Serial bit not shifted in at the low end");

  a_word_on_last: assert property (  // [R12]
    @(negedge i_sclk) disable iff (!i_arst_n)
    last_bit && !i_sync_n |=> o_word == $past(nxt_shift) && o_done_tgl != $past(o_done_tgl))
    else $error("Completed word not handed over");

  a_no_early_done: assert property (  // [R13]
    @(negedge i_sclk) disable iff (!i_arst_n)
    !last_bit |=> $stable(o_done_tgl))
    else $error("Frame completion before the sixteenth edge");
endmodule

// *** qdsl_top.sv ***
// Quad DAC serial load logic: frame decode, input and DAC registers, power control
// Overview of operation
// R1: Each frame captures exactly one 16-bit command word.
// R2: Words arrive MSB first; four control bits then the code field.
// R3: Top two bits select channel A, B, C or D.
// R4: Power bit 0 powers all channels down; 1 runs normally.
// R5: Update bit 0 refreshes all DAC registers at frame end.
// R6: Update bit 1 writes only the addressed input register.
// R7: Code keeps the upper 12, 10 or 8 bits of the field.
// R8: Code is plain unsigned binary.
// R9: Frame select low enables reception; host holds it low throughout.
// R10: One bit shifts in per falling serial clock edge, sixteen edges.
// R11: Edges after the sixteenth are ignored until a new frame.
// R12: A complete word loads the addressed input register.
// R13: Frame select rising early aborts with no register change.
// R14: Input stage enabled at frame start, disabled after sixteen bits.
// R15: Simultaneous update reloads only channels written since their last update.
// R16: Power-down never changes input or DAC register contents.
// R17: Power-up acts from the sixteenth edge; output moves after 2.5 us.
// R18: Byte-wide hosts keep frame select low across two bytes.
// R19: Host changes data on rising edges; device samples falling edges.
// R20: Reset clears all registers and starts in normal operation.
// R21: DAC codes and power-down flag change only at a valid frame end.
`timescale 1ns/100ps
module qdsl_top #(
  parameter int unsigned DAC_W = 12
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_core_en,
  input  wire logic              i_sclk,
  input  wire logic              i_sync_n,
  input  wire logic              i_din,
  output logic [DAC_W-1:0]       o_dac_code_a,
  output logic [DAC_W-1:0]       o_dac_code_b,
  output logic [DAC_W-1:0]       o_dac_code_c,
  output logic [DAC_W-1:0]       o_dac_code_d,
  output logic                   o_power_down,
  output logic                   o_out_active
);
  generate
    if (DAC_W != 8 && DAC_W != 10 && DAC_W != 12) begin : g_bad_width
      $error("DAC_W must be 8, 10 or 12");
    end
  endgenerate

  logic [qdsl_pkg::WORD_W-1:0]   link_word;
  logic                          link_done_tgl;
  logic                          tgl_s1_ff;
  logic                          tgl_s2_ff;
  logic                          tgl_s3_ff;
  logic [DAC_W-1:0]              in_code_ff  [qdsl_pkg::NUM_CH];
  logic [DAC_W-1:0]              dac_code_ff [qdsl_pkg::NUM_CH];
  logic [DAC_W-1:0]              nxt_in_code [qdsl_pkg::NUM_CH];
  logic [qdsl_pkg::NUM_CH-1:0]   dirty_ff;
  logic [qdsl_pkg::NUM_CH-1:0]   nxt_dirty;
  logic [qdsl_pkg::NUM_CH-1:0]   load_dac;
  logic                          power_down_ff;
  logic                          out_active_ff;
  logic [qdsl_pkg::PWRUP_W-1:0]  pwrup_cnt_ff;

  qdsl_link_rx u_link_rx (
    .i_sclk     (i_sclk),
    .i_arst_n   (i_arst_n),
    .i_sync_n   (i_sync_n),
    .i_din      (i_din),
    .o_word     (link_word),
    .o_done_tgl (link_done_tgl)
  );

  // Toggle crossing; word is stable long before the next frame can end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgl_s1_ff <= 1'h0;
      tgl_s2_ff <= 1'h0;
      tgl_s3_ff <= 1'h0;
    end else if (i_core_en) begin
      tgl_s1_ff <= link_done_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  wire frame_pulse = i_core_en & (tgl_s2_ff ^ tgl_s3_ff);  // [R12]
  wire [qdsl_pkg::CH_SEL_W-1:0] ch_sel =
    link_word[qdsl_pkg::CH_SELECT_HI:qdsl_pkg::CH_SELECT_LO];  // [R3]
  wire power_ctl_bit  = link_word[qdsl_pkg::PWR_CTL_POS];
  wire update_all_bit = link_word[qdsl_pkg::UPD_ALL_POS];
  // Narrow variants keep the leading bits and drop the trailing ones
  wire [DAC_W-1:0] frame_code = link_word[qdsl_pkg::CODE_MSB -: DAC_W];  // [R7] [R8]

  genvar g;
  generate
    for (g = 0; g < qdsl_pkg::NUM_CH; g++) begin : g_ch
      wire hit = frame_pulse && (ch_sel == qdsl_pkg::CH_SEL_W'(g));  // [R3]
      assign nxt_in_code[g] = hit ? frame_code : in_code_ff[g];  // [R12] [R6]
      assign nxt_dirty[g]   = hit | dirty_ff[g];
      // Only channels with a fresh input code are reloaded
      assign load_dac[g]    = frame_pulse && !update_all_bit && nxt_dirty[g];  // [R5] [R15]

      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin  // [R20]
          in_code_ff[g]  <= '0;
          dac_code_ff[g] <= '0;
          dirty_ff[g]    <= 1'h0;
        end else if (i_core_en) begin
          in_code_ff[g] <= nxt_in_code[g];
          dirty_ff[g]   <= nxt_dirty[g] & ~load_dac[g];
          if (load_dac[g]) begin  // [R6] [R16]
            dac_code_ff[g] <= nxt_in_code[g];
          end
        end
      end
    end
  endgenerate

  // Power state and wake-up delay toward the output stage
  wire leaving_pd = frame_pulse && power_ctl_bit && power_down_ff;
  wire entering_pd = frame_pulse && !power_ctl_bit;
  wire [qdsl_pkg::PWRUP_W-1:0] nxt_pwrup_cnt =
    leaving_pd ? qdsl_pkg::PWRUP_W'(qdsl_pkg::PWRUP_CYC) :
    (pwrup_cnt_ff != '0) ? pwrup_cnt_ff - qdsl_pkg::PWRUP_W'(1) : pwrup_cnt_ff;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin  // [R20]
      power_down_ff <= qdsl_pkg::PD_RST;
      out_active_ff <= qdsl_pkg::ACTIVE_RST;
      pwrup_cnt_ff  <= '0;
    end else if (i_core_en) begin
      if (frame_pulse) begin  // [R4] [R17]
        power_down_ff <= ~power_ctl_bit;
      end
      pwrup_cnt_ff  <= nxt_pwrup_cnt;  // [R17]
      out_active_ff <= !entering_pd && !leaving_pd && !power_down_ff && (nxt_pwrup_cnt == '0);
    end
  end

  assign o_dac_code_a = dac_code_ff[0];  // [R21]
  assign o_dac_code_b = dac_code_ff[1];
  assign o_dac_code_c = dac_code_ff[2];
  assign o_dac_code_d = dac_code_ff[3];
  assign o_power_down = power_down_ff;
  assign o_out_active = out_active_ff;

  a_input_load: assert property (  // [R12]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    frame_pulse |=> in_code_ff[$past(ch_sel)] == $past(frame_code))
    else $error("Addressed input register not loaded");

  a_pd_follow_bit: assert property (  // [R4]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    frame_pulse |=> power_down_ff == !$past(power_ctl_bit))
    else $error("Power-down flag does not follow the frame");

  a_dac_hold_latched: assert property (  // [R6]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    frame_pulse && update_all_bit |=> $stable(dac_code_ff[0]) && $stable(dac_code_ff[1])
      && $stable(dac_code_ff[2]) && $stable(dac_code_ff[3]))
    else $error("DAC register changed without simultaneous update");

  a_dac_update_all: assert property (  // [R5]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    frame_pulse && !update_all_bit |=> dac_code_ff[$past(ch_sel)] == $past(frame_code)
      && dirty_ff == '0)
    else $error("Simultaneous update missed a channel");

  a_clean_no_reload: assert property (  // [R15]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    frame_pulse && !update_all_bit && !dirty_ff[0] && ch_sel != 2'h0
      |=> $stable(dac_code_ff[0]))
    else $error("Unwritten channel reloaded");

  a_quiet_outputs: assert property (  // [R21]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !frame_pulse |=> $stable(power_down_ff) && $stable(dac_code_ff[1]))
    else $error("Outputs changed without a frame");

  a_pd_keeps_regs: assert property (  // [R16]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    frame_pulse && !power_ctl_bit && update_all_bit && ch_sel != 2'h2
      |=> $stable(in_code_ff[2]))
    else $error("Power-down disturbed a register");

  a_wake_delay: assert property (  // [R17]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    leaving_pd && i_core_en |=> !out_active_ff && pwrup_cnt_ff == 250)
    else $error("Wake-up delay not started at its full count");

  a_wake_end: assert property (  // [R17]
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_core_en && pwrup_cnt_ff == 1 && !frame_pulse && !power_down_ff |=> out_active_ff)
    else $error("Output not released when wake-up count ended");
endmodule

// *** qdsl_host_model.sv ***
// Host serial master model: frame select, serial clock and data
`timescale 1ns/100ps
module qdsl_host_model (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_din
);
  initial begin
    o_sclk   = 1'h1;
    o_sync_n = 1'h1;
    o_din    = 1'h0;
  end

  // Sends the top n bits of w; clock idles high and stands still between frames
  task automatic send(input logic [19:0] w, input int n, input bit split);
    int i;
    #3;
    o_sync_n = 1'h0;
    #40;
    for (i = 0; i < n; i++) begin
      o_din = w[19-i];
      #40 o_sclk = 1'h0;
      #40 o_sclk = 1'h1;
      if (split && i == 7) #200;
    end
    #20 o_sync_n = 1'h1;
    o_din = ~o_din;
  endtask
endmodule

// *** quad_dac_serial_load_logic_bench.sv ***
// Self-checking bench for the quad DAC serial load logic
`timescale 1ns/100ps
module quad_dac_serial_load_logic_bench;
  logic        i_core_clk, i_arst_n, i_core_en, sclk, sync_n, din, pd, act, pd_m;
  logic [11:0] code [4];
  logic [11:0] in_m [4];
  logic [11:0] dac_m [4];
  logic        dirty [4];
  logic [15:0] w;
  int          n_errors, num_checks, cyc;

  qdsl_host_model u_host (.o_sclk(sclk), .o_sync_n(sync_n), .o_din(din));
  qdsl_top #(.DAC_W(12)) u_dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_core_en(i_core_en),
    .i_sclk(sclk), .i_sync_n(sync_n), .i_din(din),
    .o_dac_code_a(code[0]), .o_dac_code_b(code[1]), .o_dac_code_c(code[2]),
    .o_dac_code_d(code[3]), .o_power_down(pd), .o_out_active(act));

  initial begin
    i_core_clk = 1'h0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask

  task automatic chk_all();
    for (int k = 0; k < 4; k++) chk(code[k], dac_m[k], "dac code");
    chk({11'h000, pd}, {11'h000, pd_m}, "power down flag");
  endtask

  // Expected register state after one complete word
  task automatic model(input logic [15:0] v);
    int c;
    c = int'(v[15:14]);
    in_m[c] = v[11:0];
    dirty[c] = 1'h1;
    pd_m = ~v[13];
    if (!v[12]) for (int k = 0; k < 4; k++) if (dirty[k]) begin
      dac_m[k] = in_m[k];
      dirty[k] = 1'h0;
    end
  endtask

  task automatic frame(input logic [15:0] v, input bit split);
    u_host.send({v, 4'h0}, 16, split);
    repeat (10) @(posedge i_core_clk);
    model(v);
    chk_all();
  endtask

  initial begin
    i_arst_n = 1'h0;
    i_core_en = 1'h1;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    pd_m = 1'h0;
    for (int k = 0; k < 4; k++) begin
      in_m[k] = 12'h000;
      dac_m[k] = 12'h000;
      dirty[k] = 1'h0;
    end
    void'($urandom(32'hFF6EF335));
    repeat (2) @(posedge i_core_clk);
    i_arst_n <= 1'h1;
    @(posedge i_core_clk);
    chk_all();
    chk({11'h000, act}, 12'h001, "active after reset");
    frame(16'h3123, 1'b0);
    frame(16'h7456, 1'b1);
    frame(16'hB789, 1'b0);
    w = 16'hE000 | 16'($urandom_range(0, 4095));
    frame(w, 1'b0);
    u_host.send({16'h2FFF, 4'h0}, 10, 1'b0);
    repeat (10) @(posedge i_core_clk);
    chk_all();
    u_host.send({16'h6ABC, 4'hF}, 20, 1'b0);
    repeat (10) @(posedge i_core_clk);
    model(16'h6ABC);
    chk_all();
    frame(16'h2555, 1'b0);
    frame(16'h9ABC, 1'b0);
    chk({11'h000, act}, 12'h000, "output off in power-down");
    frame(16'h3DEF, 1'b0);
    chk({11'h000, act}, 12'h000, "wake delay start");
    repeat (225) @(posedge i_core_clk);
    chk({11'h000, act}, 12'h000, "wake delay running");
    repeat (30) @(posedge i_core_clk);
    chk({11'h000, act}, 12'h001, "wake delay done");
    i_core_en <= 1'h0;
    u_host.send({16'h1A5A, 4'h0}, 16, 1'b0);
    repeat (10) @(posedge i_core_clk);
    chk_all();
    i_core_en <= 1'h1;
    repeat (10) @(posedge i_core_clk);
    model(16'h1A5A);
    chk_all();
    repeat (12) begin
      w = 16'($urandom);
      w[13] = 1'h1;
      frame(w, w[0]);
    end
    end_of_test();
  end
endmodule
